// File: rtl/breaker_failure_timer_logic.sv
// Decided for this implementation: the address map and the APB slave port.
`default_nettype none
module breaker_failure_timer_logic #(
  parameter int TICK_CYCLES = bf_pkg::TICK_CYC
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RESETN,
  input  wire logic [7:0]  PADDR,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [15:0] PHASE_L1,
  input  wire logic [15:0] PHASE_L2,
  input  wire logic [15:0] PHASE_L3,
  input  wire logic [15:0] RES_IN1,
  input  wire logic [15:0] RES_IN2,
  input  wire logic [15:0] RES_CALC,
  input  wire logic [7:0]  TRIP_RELAYS,
  input  wire logic [7:0]  TRIP_SIGNALS,
  input  wire logic        BLOCK_IN,
  output logic             START_OUT,
  output logic             BLOCKED_OUT,
  output logic             RETRIP_OUT,
  output logic             BREAKER_FAILURE_OUTPUT
);

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic [3:0]  mode;
    logic [1:0]  res_sel;
    logic        rt_en;
    logic [15:0] rt_dly;
    logic [15:0] bf_dly;
    logic [15:0] ph_thr;
    logic [15:0] rs_thr;
    logic [7:0]  mask;
    logic [31:0] rdata;
    logic [2:0]  blk_sync;   // [0] first stage, [1] second, [2] per-tick copy
    logic [15:0] cur_sync1;  // first stage: only feeds second
    logic [15:0] cur_sync2;
    logic [15:0] ph_sync1;   // first stage: only feeds second
    logic [15:0] ph_sync2;
    logic [7:0]  do_sync1;
    logic [7:0]  do_sync2;
    logic [7:0]  sig_sync1;
    logic [7:0]  sig_sync2;
    logic [31:0] div;
    logic        ph_pick;
    logic        rs_pick;
    logic [15:0] elapsed;
    logic        start;
    logic        blocked;
    logic        retrip;
    logic        bfail;
  } state_s;

  state_s s_q;
  state_s s_d;

  // current pick-up with fixed release ratio
  function automatic logic pick(input logic [15:0] meas, input logic [15:0] thr,
                                input logic was);
    logic [31:0] m100;
    logic [31:0] t97;
    m100 = 32'(meas) * 32'(bf_pkg::HYST_DEN);
    t97  = 32'(thr) * 32'(bf_pkg::HYST_NUM);
    if (was) pick = (m100 >= t97);
    else     pick = (meas > thr);
  endfunction

  // the three phase levels are reduced to one max to save synchroniser width
  logic [15:0] ph_max;
  logic [15:0] res_val;
  always_comb begin
    ph_max = PHASE_L1;
    if (PHASE_L2 > ph_max) ph_max = PHASE_L2;
    if (PHASE_L3 > ph_max) ph_max = PHASE_L3;
  end

  // residual source select
  always_comb begin
    case (s_q.res_sel)
      2'h1:    res_val = RES_IN1;
      2'h2:    res_val = RES_IN2;
      2'h3:    res_val = RES_CALC;
      default: res_val = 16'h0000;
    endcase
  end

  // combinational view of the current tick
  logic        tick;
  logic        cur;
  logic        dom;
  logic        sig;
  logic        pickup;
  logic        run;
  logic        wr;
  logic        rd;
  logic [15:0] elapsed_n;
  logic [2:0]  status;

  always_comb begin
    tick = (s_q.div == 32'(TICK_CYCLES - 1));
    cur  = s_q.ph_pick | s_q.rs_pick;
    dom  = |(s_q.do_sync2 & s_q.mask);              // watched relays
    sig  = |s_q.sig_sync2;
    // criterion decides pick-up and whether timers may count
    pickup = 1'b0;
    run    = 1'b0;
    case (s_q.mode)
      bf_pkg::M_CUR: begin
        pickup = cur;                               // trip ignored
        run    = cur;                               // drop-out resets
      end
      bf_pkg::M_DO: begin
        pickup = dom;
        run    = dom;
      end
      bf_pkg::M_SIG: begin
        pickup = sig;
        run    = sig;
      end
      bf_pkg::M_CUR_AND_DO: begin
        pickup = cur;
        run    = cur & dom;                         // halted until trip
      end
      bf_pkg::M_CUR_OR_DO: begin
        pickup = cur | dom;                         // either condition
        run    = cur | dom;                         // reset needs both gone
      end
      bf_pkg::M_CUR_AND_SIG: begin
        pickup = cur;
        run    = cur & sig;
      end
      bf_pkg::M_CUR_OR_SIG: begin
        pickup = cur | sig;
        run    = cur | sig;
      end
      bf_pkg::M_SIG_AND_DO: begin
        pickup = sig;
        run    = sig & dom;
      end
      bf_pkg::M_SIG_OR_DO: begin
        pickup = sig | dom;
        run    = sig | dom;
      end
      bf_pkg::M_ALL_AND: begin
        pickup = cur;
        run    = cur & sig & dom;
      end
      bf_pkg::M_ALL_OR: begin
        pickup = cur | sig | dom;
        run    = cur | sig | dom;
      end
      default: begin
        pickup = 1'b0;
        run    = 1'b0;
      end
    endcase
    // one counter serves both delays, so both start together
    elapsed_n = (s_q.elapsed == 16'hffff) ? s_q.elapsed : s_q.elapsed + 16'h0001;
    wr = PSEL & PENABLE & PWRITE;
    rd = PSEL & ~PWRITE;
    if (s_q.blocked)     status = bf_pkg::ST_BLOCKED;
    else if (s_q.bfail)  status = bf_pkg::ST_BFAIL;
    else if (s_q.retrip) status = bf_pkg::ST_RETRIP;
    else if (s_q.start)  status = bf_pkg::ST_START;
    else                 status = bf_pkg::ST_NORMAL;
  end

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    s_d = s_q;
    // two-flop synchronisers for pins
    s_d.blk_sync[0] = BLOCK_IN;
    s_d.blk_sync[1] = s_q.blk_sync[0];
    s_d.cur_sync1   = res_val;
    s_d.cur_sync2   = s_q.cur_sync1;
    s_d.ph_sync1    = ph_max;
    s_d.ph_sync2    = s_q.ph_sync1;
    s_d.do_sync1    = TRIP_RELAYS;
    s_d.do_sync2    = s_q.do_sync1;
    s_d.sig_sync1   = TRIP_SIGNALS;
    s_d.sig_sync2   = s_q.sig_sync1;
    s_d.div = tick ? 32'h0000_0000 : s_q.div + 32'h0000_0001;

    // program cycle evaluation
    if (tick) begin
      // residual pick-up; phase handled from the sampled max below
      s_d.rs_pick = (s_q.res_sel != 2'h0) & pick(s_q.cur_sync2, s_q.rs_thr, s_q.rs_pick);
      s_d.ph_pick = pick(s_q.ph_sync2, s_q.ph_thr, s_q.ph_pick);
      s_d.blk_sync[2] = s_q.blk_sync[1];            // sampled once per cycle
      if (!pickup) begin
        s_d.start   = 1'b0;
        s_d.blocked = 1'b0;
        s_d.retrip  = 1'b0;
        s_d.bfail   = 1'b0;
        s_d.elapsed = 16'h0000;
      end else if (s_q.blk_sync[1]) begin
        // blocked: release as on drop-out
        s_d.blocked = 1'b1;
        s_d.start   = 1'b0;
        s_d.retrip  = 1'b0;
        s_d.bfail   = 1'b0;
        s_d.elapsed = 16'h0000;
      end else begin
        s_d.blocked = 1'b0;
        s_d.start   = 1'b1;
        if (run) begin
          s_d.elapsed = elapsed_n;
          // outputs on first tick reaching delay
          if (s_q.rt_en && elapsed_n >= s_q.rt_dly) s_d.retrip = 1'b1;
          if (elapsed_n >= s_q.bf_dly) s_d.bfail = 1'b1;
        end else begin
          s_d.elapsed = 16'h0000;                   // halted or reset
          s_d.retrip  = 1'b0;
          s_d.bfail   = 1'b0;
        end
      end
      if (!s_q.rt_en) s_d.retrip = 1'b0;
    end

    // apb register writes
    if (wr) begin
      case (PADDR)
        bf_pkg::CTRL_OFS: begin
          s_d.mode    = PWDATA[bf_pkg::CTRL_MODE_LSB +: 4];
          s_d.res_sel = PWDATA[bf_pkg::CTRL_RES_LSB +: 2];
          s_d.rt_en   = PWDATA[bf_pkg::CTRL_RT_EN];
        end
        bf_pkg::RT_DLY_OFS: s_d.rt_dly = PWDATA[15:0];
        bf_pkg::BF_DLY_OFS: s_d.bf_dly = PWDATA[15:0];
        bf_pkg::PH_THR_OFS: s_d.ph_thr = PWDATA[15:0];
        bf_pkg::RS_THR_OFS: s_d.rs_thr = PWDATA[15:0];
        bf_pkg::MASK_OFS:   s_d.mask   = PWDATA[7:0];
        default: ;
      endcase
    end

    // read data captured in setup so the access phase returns it
    if (rd && !PENABLE) begin
      case (PADDR)
        bf_pkg::CTRL_OFS:   s_d.rdata = {23'h0, s_q.rt_en, 2'h0, s_q.res_sel, s_q.mode};
        bf_pkg::RT_DLY_OFS: s_d.rdata = {16'h0, s_q.rt_dly};
        bf_pkg::BF_DLY_OFS: s_d.rdata = {16'h0, s_q.bf_dly};
        bf_pkg::PH_THR_OFS: s_d.rdata = {16'h0, s_q.ph_thr};
        bf_pkg::RS_THR_OFS: s_d.rdata = {16'h0, s_q.rs_thr};
        bf_pkg::MASK_OFS:   s_d.rdata = {24'h0, s_q.mask};
        bf_pkg::STAT_OFS:   s_d.rdata = {13'h0, s_q.elapsed, status};
        default:            s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      s_q         <= '0;
      s_q.mode    <= bf_pkg::MODE_RST;
      s_q.res_sel <= bf_pkg::RES_RST;
      s_q.rt_en   <= bf_pkg::RT_EN_RST;
      s_q.rt_dly  <= bf_pkg::RT_DLY_RST;
      s_q.bf_dly  <= bf_pkg::BF_DLY_RST;
      s_q.ph_thr  <= bf_pkg::PH_THR_RST;
      s_q.rs_thr  <= bf_pkg::RS_THR_RST;
      s_q.mask    <= bf_pkg::MASK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs; zero-wait apb, unmapped addresses answer with an error
  always_comb begin
    PRDATA  = s_q.rdata;
    PREADY  = 1'b1;
    PSLVERR = PSEL & PENABLE & (PADDR > bf_pkg::STAT_OFS | PADDR[1:0] != 2'h0
              | (PWRITE & PADDR == bf_pkg::STAT_OFS));
    START_OUT              = s_q.start;
    BLOCKED_OUT            = s_q.blocked;
    RETRIP_OUT             = s_q.retrip;
    BREAKER_FAILURE_OUTPUT = s_q.bfail;
  end

endmodule
`default_nettype wire

// File: rtl/bf_pkg.sv
// Summary of operation
// - blocking input is sampled once per program cycle and held for that cycle.
// - pick-up without blocking raises start; the criterion decides when the delay timers run.
// - pick-up while blocked raises blocked; timers and outputs stay idle.
// - blocking after start clears start and releases like a pick-up drop-out.
// - redundant-trip and breaker-failure timers start together from one pick-up.
// - retrip enable, default on, gates the redundant-trip output and its delay.
// - redundant-trip output after its delay, 5 ms steps, default 100 ms.
// - breaker-failure output after its delay, 5 ms steps, default 200 ms.
// - read-only status: normal, start, retrip, breaker failure, blocked.
// - current-only criterion starts timers on current, ignores trip output.
// - current-only criterion resets timers once all currents drop out.
// - current-and-trip criterion halts timers until trip output is active.
// - current-and-trip criterion resets on current drop or trip release.
// - current-or-trip criterion picks up on either condition.
// - current-or-trip criterion resets only when both conditions are gone.
// - current-or-trip retrip asserts when either stayed active for its delay.
// - current-or-trip breaker failure asserts when either stayed for its delay.
// - with retrip disabled only the breaker-failure timer drives an output.
// - current pick-up releases at 97 percent of its threshold.
// - criterion select chooses current, signals, outputs or combinations; default current.
// - residual source select: none, input one, input two, or computed.
// - trip-monitor mask selects watched primary output relays.
`default_nettype none
package bf_pkg;

  // ***************************************************************
  // register map (byte addresses)
  // ***************************************************************
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] RT_DLY_OFS = 8'h04;
  localparam logic [7:0] BF_DLY_OFS = 8'h08;
  localparam logic [7:0] PH_THR_OFS = 8'h0c;
  localparam logic [7:0] RS_THR_OFS = 8'h10;
  localparam logic [7:0] MASK_OFS   = 8'h14;
  localparam logic [7:0] STAT_OFS   = 8'h18;

  // ***************************************************************
  // control fields
  // ***************************************************************
  localparam int CTRL_MODE_LSB = 0;  // 4 bits criterion select
  localparam int CTRL_RES_LSB  = 4;  // 2 bits residual source
  localparam int CTRL_RT_EN    = 8;  // retrip enable

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [3:0]  MODE_RST   = 4'h0;        // current only
  localparam logic [1:0]  RES_RST    = 2'h0;        // not in use
  localparam logic        RT_EN_RST  = 1'b1;
  localparam logic [15:0] RT_DLY_RST = 16'h0014;    // 20 steps = 0.100 s
  localparam logic [15:0] BF_DLY_RST = 16'h0028;    // 40 steps = 0.200 s
  localparam logic [15:0] PH_THR_RST = 16'h0014;    // 0.20 x In in 0.01 units
  localparam logic [15:0] RS_THR_RST = 16'h04b0;    // 1.200 x In in 0.001 units
  localparam logic [7:0]  MASK_RST   = 8'h00;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_HZ         = 10_000_000;
  localparam int TICK_US        = 5000;            // program cycle, 5 ms
  localparam int TICK_CYC       = TICK_US * (CLK_HZ / 1_000_000);
  localparam int BLOCK_LEAD_MS  = 5;               // far-side lead for blocking
  localparam int HYST_NUM       = 97;              // release ratio percent
  localparam int HYST_DEN       = 100;

  // ***************************************************************
  // criteria and status
  // ***************************************************************
  localparam logic [3:0] M_CUR      = 4'h0;
  localparam logic [3:0] M_DO       = 4'h1;
  localparam logic [3:0] M_SIG      = 4'h2;
  localparam logic [3:0] M_CUR_AND_DO  = 4'h3;
  localparam logic [3:0] M_CUR_OR_DO   = 4'h4;
  localparam logic [3:0] M_CUR_AND_SIG = 4'h5;
  localparam logic [3:0] M_CUR_OR_SIG  = 4'h6;
  localparam logic [3:0] M_SIG_AND_DO  = 4'h7;
  localparam logic [3:0] M_SIG_OR_DO   = 4'h8;
  localparam logic [3:0] M_ALL_AND     = 4'h9;
  localparam logic [3:0] M_ALL_OR      = 4'ha;

  localparam logic [2:0] ST_NORMAL  = 3'h0;
  localparam logic [2:0] ST_START   = 3'h1;
  localparam logic [2:0] ST_RETRIP  = 3'h2;
  localparam logic [2:0] ST_BFAIL   = 3'h3;
  localparam logic [2:0] ST_BLOCKED = 3'h4;

endpackage
`default_nettype wire

// File: bench/bf_asserts.sv
`default_nettype none
module bf_asserts #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic       CORE_CLK,
  input wire logic       RESETN,
  input wire logic [7:0] PADDR,
  input wire logic       PSEL,
  input wire logic       PENABLE,
  input wire logic       PWRITE,
  input wire logic       PREADY,
  input wire logic       PSLVERR,
  input wire logic       START_OUT,
  input wire logic       BLOCKED_OUT,
  input wire logic       RETRIP_OUT,
  input wire logic       BREAKER_FAILURE_OUTPUT
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // port checks, all in the core clock domain
  // ****************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  a_ready_high: assert property (PSEL && PENABLE |-> PREADY) else $error("pready low");
  a_stat_readonly: assert property (
    PSEL && PENABLE && PWRITE && PADDR == bf_pkg::STAT_OFS |-> PSLVERR)
    else $error("status write accepted");
  a_map_ok: assert property (
    PSEL && PENABLE && !PWRITE && PADDR <= 8'h18 && PADDR[1:0] == 2'h0 |-> !PSLVERR)
    else $error("mapped read refused");
  a_unmapped_err: assert property (
    PSEL && PENABLE && (PADDR > 8'h18 || PADDR[1:0] != 2'h0) |-> PSLVERR)
    else $error("unmapped access accepted");
  a_block_quiet: assert property (
    BLOCKED_OUT |-> !(START_OUT || RETRIP_OUT || BREAKER_FAILURE_OUTPUT))
    else $error("blocked with activity");
  // outputs move only on ticks, so a new start stands a whole tick
  a_start_held: assert property ($rose(START_OUT) |=> $stable(START_OUT) [*8])
    else $error("start shorter than a tick");
  a_bf_held: assert property (
    $rose(BREAKER_FAILURE_OUTPUT) |=> BREAKER_FAILURE_OUTPUT [*8])
    else $error("failure output glitch");
  // a zero or one tick delay may raise an output on the start tick itself
  a_rt_after_start: assert property (RETRIP_OUT |-> START_OUT)
    else $error("retrip without start");
  a_bf_after_start: assert property (
    BREAKER_FAILURE_OUTPUT |-> START_OUT)
    else $error("failure without start");
  a_release_all: assert property (
    $fell(START_OUT) |-> !RETRIP_OUT && !BREAKER_FAILURE_OUTPUT)
    else $error("outputs survive release");
  a_reset_clear: assert property (
    $rose(RESETN) |-> !(START_OUT || BLOCKED_OUT || RETRIP_OUT || BREAKER_FAILURE_OUTPUT))
    else $error("outputs active after reset");
endmodule
bind breaker_failure_timer_logic bf_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk_i (
  .CORE_CLK(CORE_CLK), .RESETN(RESETN), .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PREADY(PREADY), .PSLVERR(PSLVERR), .START_OUT(START_OUT),
  .BLOCKED_OUT(BLOCKED_OUT), .RETRIP_OUT(RETRIP_OUT),
  .BREAKER_FAILURE_OUTPUT(BREAKER_FAILURE_OUTPUT));
`default_nettype wire

// File: bench/bf_partner.sv
`default_nettype none
module bf_partner #(
  parameter int TRIP_LAT = 40,
  parameter int BRK_LAT  = 30
) (
  input  wire logic        clk,
  input  wire logic        fault,
  input  wire logic        stuck,
  input  wire logic        trip_off,
  input  wire logic [15:0] amp,
  output logic [15:0]      phase,
  output logic [7:0]       relays
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial phase = 16'h0000;
  initial relays = 8'h00;
  // primary stage trips after a latency; a stuck breaker never interrupts
  always @(posedge clk) begin
    cnt <= fault ? cnt + 1 : 0;
    phase <= (fault && (stuck || cnt < TRIP_LAT + BRK_LAT)) ? amp : 16'h0000;
    relays <= {7'h00, fault && !trip_off && cnt >= TRIP_LAT};
  end
endmodule
`default_nettype wire

// File: bench/breaker_failure_timer_logic_bench.sv
`default_nettype none
module breaker_failure_timer_logic_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int T = 10;  // short tick keeps the run brief
  logic clk = 0, rstn, psel, penable, pwrite, fault, stuck, toff, blk;
  logic [7:0] paddr, relays, sig;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] amp, phase, res;
  logic pready, pslverr, e, st, bo, rt, bfo;
  logic [3:0] outs;
  int miscompares = 0, cmp_count = 0, cyc = 0, t0, t1, t2;
  logic [31:0] rv [7] = '{32'h100, 32'h14, 32'h28, 32'h14, 32'h4b0, 32'h0, 32'h0};
  assign outs = {bfo, rt, bo, st};
  // ****************************************
  // clock, design and far side
  // ****************************************
  initial forever #50 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  breaker_failure_timer_logic #(.TICK_CYCLES(T)) uut (
    .CORE_CLK(clk), .RESETN(rstn), .PADDR(paddr), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PHASE_L1(phase), .PHASE_L2(phase), .PHASE_L3(phase), .RES_IN1(res),
    .RES_IN2(16'h0000), .RES_CALC(16'h0000), .TRIP_RELAYS(relays), .TRIP_SIGNALS(sig),
    .BLOCK_IN(blk), .START_OUT(st), .BLOCKED_OUT(bo), .RETRIP_OUT(rt),
    .BREAKER_FAILURE_OUTPUT(bfo));
  bf_partner prim (.clk(clk), .fault(fault), .stuck(stuck), .trip_off(toff), .amp(amp),
    .phase(phase), .relays(relays));
  // ****************************************
  // access and compare tasks
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chkr(input string n, input int lo, input int hi, input int g);
    cmp_count++;
    if (g < lo || g > hi) begin
      miscompares++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask
  // bounded wait for one output level; a lapse shows as a mismatch
  task automatic waitfor(input int s, input logic v);
    int n = 0;
    while (outs[s] !== v && n < 500) begin
      @(posedge clk);
      n++;
    end
    chk("output level", {31'h0, v}, {31'h0, outs[s]});
  endtask
  task automatic summarize();
    if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog far beyond the planned sequence
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    summarize();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {fault, toff, blk} = '0;
    res = 16'h0000;
    sig = 8'h00;
    stuck = 1'b1;
    amp = 16'h0100;
    rstn = 1'b0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("reset value", rv[i], q);
    end
    apb(1'b1, bf_pkg::STAT_OFS, 32'h3);
    chk("status write refused", 32'h1, {31'h0, e});
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped data", 32'h0, q);
    apb(1'b1, bf_pkg::RT_DLY_OFS, 32'h3);
    apb(1'b1, bf_pkg::BF_DLY_OFS, 32'h6);
    // current only, stuck breaker: both timers from one pick-up
    fault <= 1'b1;
    waitfor(0, 1'b1); t0 = cyc;
    waitfor(2, 1'b1); t1 = cyc;
    waitfor(3, 1'b1); t2 = cyc;
    chkr("retrip delay", 2 * T, 3 * T, t1 - t0);
    chk("timer spacing", 32'(3 * T), 32'(t2 - t1));
    apb(1'b0, bf_pkg::STAT_OFS, 32'h0);
    chk("status failure", 32'(bf_pkg::ST_BFAIL), q & 32'h7);
    fault <= 1'b0;
    waitfor(0, 1'b0);
    chk("failure released", 32'h0, {31'h0, bfo});
    // blocking before and after pick-up
    blk <= 1'b1;
    repeat (3 * T) @(posedge clk);
    fault <= 1'b1;
    waitfor(1, 1'b1);
    apb(1'b0, bf_pkg::STAT_OFS, 32'h0);
    chk("status blocked", 32'(bf_pkg::ST_BLOCKED), q & 32'h7);
    blk <= 1'b0;
    waitfor(0, 1'b1);
    blk <= 1'b1;
    waitfor(0, 1'b0);
    chk("no retrip after block", 32'h0, {31'h0, rt});
    {fault, blk} <= 2'b00;
    repeat (3 * T) @(posedge clk);
    // current and trip output: halted until the relay acts
    apb(1'b1, bf_pkg::MASK_OFS, 32'h1);
    apb(1'b1, bf_pkg::CTRL_OFS, 32'h103);
    fault <= 1'b1; t0 = cyc;
    waitfor(2, 1'b1);
    chkr("held until trip", 40 + 2 * T, 43 + 4 * T, cyc - t0);
    toff <= 1'b1;
    waitfor(2, 1'b0);
    {fault, toff} <= 2'b00;
    repeat (3 * T) @(posedge clk);
    // current or trip output: either alone holds the timers
    apb(1'b1, bf_pkg::CTRL_OFS, 32'h104);
    amp <= 16'h0000;
    fault <= 1'b1;
    waitfor(2, 1'b1);
    fault <= 1'b0;
    waitfor(0, 1'b0);
    {amp, toff, fault} <= {16'h0100, 2'b11};
    waitfor(3, 1'b1);
    {fault, toff} <= 2'b00;
    waitfor(0, 1'b0);
    // retrip disabled; hysteresis on the phase threshold of 20
    apb(1'b1, bf_pkg::CTRL_OFS, 32'h000);
    {amp, fault} <= {16'd21, 1'b1};
    waitfor(3, 1'b1);
    chk("retrip disabled", 32'h0, {31'h0, rt});
    amp <= 16'd20;
    repeat (3 * T) @(posedge clk);
    chk("above release level", 32'h1, {31'h0, st});
    amp <= 16'd19;
    waitfor(0, 1'b0);
    // residual input one above its threshold of 1200, phases below theirs
    apb(1'b1, bf_pkg::CTRL_OFS, 32'h110);
    res <= 16'd1201;
    waitfor(0, 1'b1);
    res <= 16'd0;
    waitfor(0, 1'b0);
    // binary signals only: any set signal runs the timers
    apb(1'b1, bf_pkg::CTRL_OFS, 32'h102);
    sig <= 8'h04;
    waitfor(3, 1'b1);
    sig <= 8'h00;
    waitfor(0, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
